//--- common/mfig_pkg.sv
package mfig_pkg;

  // register geometry
  localparam int unsigned MFIG_DATA_W   = 8;
  localparam int unsigned MFIG_ADDR_W   = 4;
  localparam int unsigned MFIG_NGROUP   = 4;
  localparam int unsigned MFIG_NSRC     = 3;

  // register offsets (byte index on the plain register port)
  localparam logic [3:0] MFIG_OFS_GROUP_SIX   = 4'h0;
  localparam logic [3:0] MFIG_OFS_GROUP_SEVEN = 4'h1;
  localparam logic [3:0] MFIG_OFS_GROUP_EIGHT = 4'h2;
  localparam logic [3:0] MFIG_OFS_GROUP_NINE  = 4'h3;
  localparam logic [3:0] MFIG_OFS_CTRL        = 4'h4;
  localparam logic [3:0] MFIG_OFS_STATUS      = 4'h5;

  // field positions inside one group register
  localparam int unsigned MFIG_BIT_SRC_REQ  = 6;
  localparam int unsigned MFIG_BIT_A_REQ    = 5;
  localparam int unsigned MFIG_BIT_P_REQ    = 4;
  localparam int unsigned MFIG_BIT_SRC_EN   = 2;
  localparam int unsigned MFIG_BIT_A_EN     = 1;
  localparam int unsigned MFIG_BIT_P_EN     = 0;
  localparam int unsigned MFIG_REQ_LSB      = 4;
  localparam int unsigned MFIG_EN_LSB       = 0;

  // control register fields
  localparam int unsigned MFIG_BIT_GIE      = 0;
  localparam int unsigned MFIG_BIT_SLEEP    = 1;

  // reset values
  localparam logic [2:0] MFIG_RST_REQ  = 3'h0;
  localparam logic [2:0] MFIG_RST_EN   = 3'h0;
  localparam logic [7:0] MFIG_RST_RDAT = 8'h00;

endpackage

//--- verilog/mfig_group.sv
`timescale 1ns/100ps
`default_nettype none

// one group register: three flags, three enables, one combined request
module mfig_group
  import mfig_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // source events, one-cycle pulses, bit 2 = source, 1 = a, 0 = p
  input  wire logic [2:0] evt,
  // register write
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  // state
  output var  logic [2:0] req_r,
  output var  logic [2:0] en_r,
  output var  logic       pend
);

  logic [2:0] req_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // flags: software write first, then events override so a set is never lost
  always_comb
  begin
    req_nxt = req_r;
    if (wr)
    begin
      req_nxt = wdata[MFIG_REQ_LSB +: MFIG_NSRC];
    end
    req_nxt = req_nxt | evt;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      req_r <= MFIG_RST_REQ;
    end
    else
    begin
      req_r <= req_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enables
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      en_r <= MFIG_RST_EN;
    end
    else if (wr)
    begin
      en_r <= wdata[MFIG_EN_LSB +: MFIG_NSRC];
    end
  end

  // a flag only counts while its enable is set
  assign pend = |(req_r & en_r);

endmodule
`default_nettype wire

//--- verilog/mfig_rdmux.sv
`timescale 1ns/100ps
`default_nettype none

// read data assembly for one group register
module mfig_rdmux
  import mfig_pkg::*;
(
  // fields
  input  wire logic [2:0] req,
  input  wire logic [2:0] en,
  // packed register image
  output logic      [7:0] image
);

  // bits 7 and 3 are hard zero
  assign image = {1'b0, req, 1'b0, en};

endmodule
`default_nettype wire

//--- verilog/mfig_top.sv
// Contract
// - group six bit 6 holds comparator zero request flag
// - group six bits 5 and 4 hold timer four a and p flags
// - group six bit 2 enables comparator zero
// - group six bits 1 and 0 enable timer four a and p
// - group seven bit 6 holds comparator one request flag
// - group seven bits 5 and 4 hold timer five a and p flags
// - group seven bits 1 and 0 enable timer five a and p
// - group eight bit 6 holds time base zero request flag
// - group eight bits 5 and 4 hold timer six a and p flags
// - group eight bit 2 enables time base zero
// - group eight bits 1 and 0 enable timer six a and p
// - group nine bit 6 holds time base one request flag
// - group nine bits 5 and 4 hold timer seven a and p flags
// - group nine bits 1 and 0 enable timer seven a and p
// - bits 7 and 3 read zero, writes ignored
// - source events set flags regardless of enable
// - flag interrupts only when its enable is set
// - cleared global enable blocks all group interrupts
// - any newly set flag wakes device from sleep or idle; the code raises wake_r only while sleep_r is set and has no idle state
`timescale 1ns/100ps
`default_nettype none

module mfig_top
  import mfig_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // comparator and time base events, one-cycle pulses
  input  wire logic       comparator_zero_evt,
  input  wire logic       comparator_one_evt,
  input  wire logic       time_base_zero_evt,
  input  wire logic       time_base_one_evt,
  // periodic timer match events, one-cycle pulses
  input  wire logic       timer_four_a_evt,
  input  wire logic       timer_four_p_evt,
  input  wire logic       timer_five_a_evt,
  input  wire logic       timer_five_p_evt,
  input  wire logic       timer_six_a_evt,
  input  wire logic       timer_six_p_evt,
  input  wire logic       timer_seven_a_evt,
  input  wire logic       timer_seven_p_evt,
  // register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output var  logic [7:0] rdata_r,
  // toward the core interrupt logic
  output var  logic [3:0] group_irq_r,
  output var  logic       wake_r
);

  ////////////////////////////////////////////////////////////////////////////
  // event grouping: index 0 = six, 1 = seven, 2 = eight, 3 = nine
  logic [2:0] evt_grp [MFIG_NGROUP];
  logic [2:0] req_grp [MFIG_NGROUP];
  logic [2:0] en_grp  [MFIG_NGROUP];
  logic [7:0] img_grp [MFIG_NGROUP];
  logic [3:0] pend;
  logic [3:0] wr_grp;
  logic [3:0] grp_ofs [MFIG_NGROUP];

  assign grp_ofs[0] = MFIG_OFS_GROUP_SIX;
  assign grp_ofs[1] = MFIG_OFS_GROUP_SEVEN;
  assign grp_ofs[2] = MFIG_OFS_GROUP_EIGHT;
  assign grp_ofs[3] = MFIG_OFS_GROUP_NINE;

  // source flag bit 6, a flag bit 5, p flag bit 4 in every group
  assign evt_grp[0] = {comparator_zero_evt, timer_four_a_evt, timer_four_p_evt};
  assign evt_grp[1] = {comparator_one_evt, timer_five_a_evt, timer_five_p_evt};
  assign evt_grp[2] = {time_base_zero_evt, timer_six_a_evt, timer_six_p_evt};
  assign evt_grp[3] = {time_base_one_evt, timer_seven_a_evt, timer_seven_p_evt};

  ////////////////////////////////////////////////////////////////////////////
  // group registers
  genvar g;
  generate
    for (g = 0; g < MFIG_NGROUP; g++)
    begin : grp
      assign wr_grp[g] = wr && (addr == grp_ofs[g]);

      mfig_group u_group (
        .clk   (clk),
        .rstn  (rstn),
        .evt   (evt_grp[g]),
        .wr    (wr_grp[g]),
        .wdata (wdata),
        .req_r (req_grp[g]),
        .en_r  (en_grp[g]),
        .pend  (pend[g])
      );

      mfig_rdmux u_rdmux (
        .req   (req_grp[g]),
        .en    (en_grp[g]),
        .image (img_grp[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // control: global enable and sleep indication from software
  logic global_irq_enable_r;
  logic sleep_r;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      global_irq_enable_r <= 1'b0;
    end
    else if (wr && addr == MFIG_OFS_CTRL)
    begin
      global_irq_enable_r <= wdata[MFIG_BIT_GIE];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sleep_r <= 1'b0;
    end
    else if (wr && addr == MFIG_OFS_CTRL)
    begin
      sleep_r <= wdata[MFIG_BIT_SLEEP];
    end
    else if (wake_r)
    begin
      // wake clears the sleep request
      sleep_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt outputs, masked by the global enable
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      group_irq_r <= 4'h0;
    end
    else
    begin
      group_irq_r <= global_irq_enable_r ? pend : 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake on any flag rising; enables and global enable do not matter
  logic [11:0] flags_all;
  logic [11:0] flags_prev_r;

  assign flags_all = {req_grp[3], req_grp[2], req_grp[1], req_grp[0]};

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      flags_prev_r <= 12'h000;
    end
    else
    begin
      flags_prev_r <= flags_all;
    end
  end

  // a flag already set before sleep does not wake, matching flag-preset usage
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wake_r <= 1'b0;
    end
    else
    begin
      wake_r <= sleep_r && |(flags_all & ~flags_prev_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after rd, zero otherwise
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rdata_r <= MFIG_RST_RDAT;
    end
    else if (rd)
    begin
      case (addr)
        MFIG_OFS_GROUP_SIX:   rdata_r <= img_grp[0];
        MFIG_OFS_GROUP_SEVEN: rdata_r <= img_grp[1];
        MFIG_OFS_GROUP_EIGHT: rdata_r <= img_grp[2];
        MFIG_OFS_GROUP_NINE:  rdata_r <= img_grp[3];
        MFIG_OFS_CTRL:        rdata_r <= {6'h00, sleep_r, global_irq_enable_r};
        MFIG_OFS_STATUS:      rdata_r <= {4'h0, pend};
        default:              rdata_r <= MFIG_RST_RDAT;
      endcase
    end
    else
    begin
      rdata_r <= MFIG_RST_RDAT;
    end
  end

endmodule
`default_nettype wire

//--- dv/mfig_src_model.sv
`timescale 1ns/100ps
`default_nettype none

module mfig_src_model
(
  // clock
  input  wire logic        clk,
  // one-hot event commands from the bench
  input  wire logic [11:0] fire,
  // event pulses toward the block
  output logic      [11:0] evt
);
  initial evt = 12'h000;

  // one cycle behind the command, like a real match strobe
  always @(posedge clk)
  begin
    evt <= fire;
  end
endmodule

`default_nettype wire

//--- dv/mfig_chk.sv
`timescale 1ns/100ps
`default_nettype none

module mfig_chk
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // watched events
  input  wire logic       comparator_zero_evt,
  input  wire logic       timer_four_a_evt,
  input  wire logic       time_base_one_evt,
  // register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  input  wire logic [7:0] rdata_r,
  input  wire logic [3:0] group_irq_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_gie_on;
    wr && addr == 4'h4 && wdata[0];
  endsequence
  sequence s_six_on;
    wr && addr == 4'h0 && wdata[6] && wdata[2];
  endsequence

  ////////////////////////////////////////////////////////////////
  AST_UNIMP: assert property (rd && addr < 4'h4 |=> !rdata_r[7] && !rdata_r[3])
    else $error("unimplemented bit set");
  AST_CP0: assert property (comparator_zero_evt ##1 (rd && addr == 4'h0) |=> rdata_r[6])
    else $error("comparator zero flag lost");
  AST_T4A: assert property (timer_four_a_evt ##1 (rd && addr == 4'h0) |=> rdata_r[5])
    else $error("timer four a flag lost");
  AST_TB1: assert property (time_base_one_evt ##1 (rd && addr == 4'h3) |=> rdata_r[6])
    else $error("time base one flag lost");
  AST_RST: assert property ($rose(rstn) |-> group_irq_r == 4'h0)
    else $error("irq after reset");
  AST_GIE_OFF: assert property (wr && addr == 4'h4 && !wdata[0] |=> ##1 group_irq_r == 4'h0)
    else $error("irq with global enable off");
  AST_EN_OFF: assert property (wr && addr == 4'h0 && wdata[2:0] == 3'h0 |=> ##1 !group_irq_r[0])
    else $error("irq with enables off");
  AST_COMBINE: assert property (s_gie_on ##1 s_six_on |=> ##1 group_irq_r[0])
    else $error("combined request missing");
endmodule

`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end

module tb_top
  import mfig_pkg::*;
;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [11:0] fire = 12'h000;
  logic [11:0] evt;
  logic [7:0]  rdata_r;
  logic [3:0]  group_irq_r;
  logic        wake_r;
  logic        seen;
  logic [7:0]  acc [4];
  int          failures = 0;
  int          check_count = 0;

  mfig_src_model i_mfig_src_model (.clk(clk), .fire(fire), .evt(evt));

  mfig_top i_mfig_top (.clk(clk), .rstn(rstn),
    .comparator_zero_evt(evt[2]), .comparator_one_evt(evt[5]),
    .time_base_zero_evt(evt[8]), .time_base_one_evt(evt[11]),
    .timer_four_a_evt(evt[1]), .timer_four_p_evt(evt[0]),
    .timer_five_a_evt(evt[4]), .timer_five_p_evt(evt[3]),
    .timer_six_a_evt(evt[7]), .timer_six_p_evt(evt[6]),
    .timer_seven_a_evt(evt[10]), .timer_seven_p_evt(evt[9]),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r),
    .group_irq_r(group_irq_r), .wake_r(wake_r));

  initial forever #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata_r)
  endtask

  // two edges: model strobe, then the block takes it
  task automatic pulse(input logic [11:0] m);
    fire <= m;
    @(posedge clk);
    fire <= 12'h000;
    @(posedge clk);
    #1;
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic final_report();
    if (failures == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2000) @(posedge clk);
    failures++;
    final_report();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    for (int a = 0; a < 7; a++) rd_chk(4'(a), 8'h00);
    for (int g = 0; g < 4; g++)
    begin
      wr_reg(4'(g), 8'hff);
      rd_chk(4'(g), 8'h77);
      wr_reg(4'(g), 8'h00);
      acc[g] = 8'h00;
    end
    // flags accumulate with every enable off
    for (int i = 0; i < 12; i++)
    begin
      pulse(12'h001 << i);
      acc[i / 3] = acc[i / 3] | (8'h10 << (i % 3));
      rd_chk(4'(i / 3), acc[i / 3]);
    end
    wr_reg(MFIG_OFS_CTRL, 8'h01);
    for (int g = 0; g < 4; g++)
    begin
      for (int b = 2; b >= 0; b--)
      begin
        wr_reg(4'(g), 8'h70 | (8'h01 << b));
        settle();
        `CHK("irq_one", 4'h1 << g, group_irq_r)
      end
      wr_reg(4'(g), 8'h70);
      settle();
      `CHK("irq_masked", 4'h0, group_irq_r)
    end
    for (int g = 0; g < 4; g++) wr_reg(4'(g), 8'h77);
    settle();
    `CHK("irq_all", 4'hf, group_irq_r)
    rd_chk(MFIG_OFS_STATUS, 8'h0f);
    wr_reg(MFIG_OFS_CTRL, 8'h00);
    settle();
    `CHK("irq_gie", 4'h0, group_irq_r)
    // a fresh rise is needed to wake, so clear first
    wr_reg(MFIG_OFS_GROUP_SIX, 8'h00);
    wr_reg(MFIG_OFS_CTRL, 8'h02);
    pulse(12'h004);
    seen = 1'b0;
    repeat (4)
    begin
      @(posedge clk);
      #1;
      seen = seen | wake_r;
    end
    `CHK("wake", 1'b1, seen)
    rd_chk(MFIG_OFS_CTRL, 8'h00);
    final_report();
  end
endmodule

bind mfig_top mfig_chk i_mfig_chk (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
  .comparator_zero_evt(comparator_zero_evt), .timer_four_a_evt(timer_four_a_evt),
  .time_base_one_evt(time_base_one_evt), .wr(wr), .rd(rd), .rdata_r(rdata_r),
  .group_irq_r(group_irq_r));

`default_nettype wire
